// ### design/pps_pkg.sv
// constants for the pll power and status register slice
package pps_pkg;
	// ==========================================
	// register word addresses
	localparam logic [7:0] PPS_ADDR_PWR = 8'h05;
	localparam logic [7:0] PPS_ADDR_CAL = 8'h06;
	localparam logic [7:0] PPS_ADDR_STAT = 8'h07;
	localparam logic [7:0] PPS_LAST_ADDR_DEF = 8'h3F;
	// ==========================================
	// reset values and masks
	localparam logic [15:0] PPS_PWR_RST = 16'h0030;
	localparam logic [15:0] PPS_CAL_RST = 16'h0000;
	localparam logic [15:0] PPS_STAT_RST = 16'h0000;
	localparam logic [15:0] PPS_STAT_RD_MASK = 16'h0FFF;
	localparam logic [10:0] PPS_PDN_POR_MASK = 11'h01A;
	localparam logic [15:0] PPS_PWR_POR_SET = 16'h001E;
	// ==========================================
	// power register bit positions
	localparam int PPS_PWR_VCOBUF_REG = 10;
	localparam int PPS_PWR_VCO_REG = 9;
	localparam int PPS_PWR_VCOBUF = 8;
	localparam int PPS_PWR_CP_REG = 7;
	localparam int PPS_PWR_LOCKDET = 6;
	localparam int PPS_PWR_FBPS = 5;
	localparam int PPS_PWR_PSA = 4;
	localparam int PPS_PWR_FODCLK = 3;
	localparam int PPS_PWR_PFD = 2;
	localparam int PPS_PWR_PS = 1;
	localparam int PPS_PWR_REF = 0;
	localparam int PPS_PDN_W = 11;
	// ==========================================
	// status register bit positions
	localparam int PPS_ST_LOCK_A = 11;
	localparam int PPS_ST_VCO_POR = 10;
	localparam int PPS_ST_NVM_RD_ERR = 9;
	localparam int PPS_ST_NVM_WR_ERR = 8;
	localparam int PPS_ST_RD_ERR = 7;
	localparam int PPS_ST_WR_ERR = 6;
	localparam int PPS_ST_CRC_ERR = 5;
	localparam int PPS_ST_BUSY = 4;
	localparam int PPS_ST_CAL_DONE = 3;
	localparam int PPS_ST_CFG_DONE = 2;
	localparam int PPS_ST_UNLOCK = 1;
	localparam int PPS_ST_LOCK = 0;
	// ==========================================
	// state of the register slice
	typedef struct packed {
		logic [15:0] pwr;
		logic [15:0] cal;
		logic [15:0] stat;
		logic [15:0] rdata;
		logic [10:0] pdn;
		logic lock_prev;
		logic por_prev;
	} pps_state_t;
endpackage : pps_pkg

// ### design/pps_regs.sv
// pll power-down control, calibration word and status register slice
// Contract
// - power register at word 5h, resets to 30h, prescaler bits 5 and 4 set
// - bits 10, 9, 8 power down vco buffer regulator, vco regulator, vco buffer
// - bits 7, 6, 5 power down charge pump regulator, lock detector, feedback prescaler
// - bits 4, 3, 1 held low during power-on reset once rst_n_in is released (reset loads bit 4 high), set high afterwards
// - bit 2 high keeps phase detector off until calibration, then cleared
// - word 6h holds read-only 16-bit calibration word, reset zero
// - status at word 7h, bit 11 analog lock, bits 15-12 reserved
// - status bit 10 shows vco regulator power-on-reset
// - bit 9 set on eeprom operation during read phase, cleared by read
// - bit 8 set on eeprom operation during write phase, cleared by read
// - bit 7 set when a read addresses beyond the last register
// - bit 6 set when a write addresses beyond the last register
// - bit 5 set on eeprom checksum mismatch during configuration
// - bit 4 reads one while an eeprom operation is in progress
// - bit 3 set once calibration has finished
// - bit 2 set once configuration has finished
// - bit 1 sticky loss of lock, cleared by recalibration or reset pin
// - bit 0 reports frequency lock
`timescale 1ns/10ps
`default_nettype none
module pps_regs
	import pps_pkg::*;
#(
	parameter logic [7:0] LAST_REG_ADDR = PPS_LAST_ADDR_DEF
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	input wire logic reset_sync_pin_n_in,
	input wire logic lock_det_in,
	input wire logic lock_det_analog_in,
	input wire logic vco_ldo_por_in,
	input wire logic por_active_in,
	input wire logic recal_start_in,
	input wire logic cal_done_evt_in,
	input wire logic [15:0] cal_word_in,
	input wire logic config_done_evt_in,
	input wire logic nvm_op_req_in,
	input wire logic nvm_rd_phase_in,
	input wire logic nvm_wr_phase_in,
	input wire logic nvm_busy_in,
	input wire logic nvm_crc_err_in,
	output logic vco_buffer_regulator_off_out,
	output logic vco_regulator_off_out,
	output logic vco_buffer_off_out,
	output logic charge_pump_regulator_off_out,
	output logic lock_detector_off_out,
	output logic fb_prescaler_off_out,
	output logic prescaler_a_off_out,
	output logic fod_clock_path_off_out,
	output logic phase_detector_off_out,
	output logic prescaler_off_out,
	output logic input_path_regulator_off_out
);
	// ==========================================
	// elaboration check
	if (LAST_REG_ADDR < PPS_ADDR_STAT) begin : g_bad_last
		$error("last register address lies below the status register");
	end
	// ==========================================
	// helpers
	function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
		hit = strobe && (addr == target);
	endfunction : hit
	pps_state_t s_reg;
	pps_state_t s_next;
	logic [2:0] pin_s;
	logic lock_s;
	logic lock_a_s;
	logic rst_pin_n_s;
	// ==========================================
	// pin synchronisers
	pps_sync #(
		.W(3)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.async_in({reset_sync_pin_n_in, lock_det_analog_in, lock_det_in}),
		.rst_val_in(3'h4),
		.sync_out(pin_s)
	);
	assign lock_s = pin_s[0];
	assign lock_a_s = pin_s[1];
	assign rst_pin_n_s = pin_s[2];
	logic vpor_s;
	pps_sync #(
		.W(1)
	) u_sync_por (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.async_in(vco_ldo_por_in),
		.rst_val_in(1'h0),
		.sync_out(vpor_s)
	);
	// ==========================================
	// next state
	logic por_end;
	logic rd_stat;
	always_comb begin
		s_next = s_reg;
		por_end = s_reg.por_prev && !por_active_in;
		rd_stat = hit(reg_rd_in, reg_addr_in, PPS_ADDR_STAT);
		s_next.por_prev = por_active_in;
		s_next.lock_prev = lock_s;
		// power register: host write, then state machine overrides
		if (hit(reg_wr_in, reg_addr_in, PPS_ADDR_PWR)) begin
			s_next.pwr = reg_wdata_in;
		end
		if (por_end) begin
			s_next.pwr = s_next.pwr | PPS_PWR_POR_SET;
		end
		if (cal_done_evt_in) begin
			s_next.pwr[PPS_PWR_PFD] = 1'b0;
		end
		s_next.pdn = s_next.pwr[PPS_PDN_W-1:0] & ~(por_active_in ? PPS_PDN_POR_MASK : 11'h000);
		// calibration word only from the calibration engine
		if (cal_done_evt_in) begin
			s_next.cal = cal_word_in;
		end
		// live status bits
		s_next.stat[PPS_ST_LOCK_A] = lock_a_s;
		s_next.stat[PPS_ST_VCO_POR] = vpor_s;
		s_next.stat[PPS_ST_BUSY] = nvm_busy_in;
		s_next.stat[PPS_ST_LOCK] = lock_s;
		// clears first, sets win
		if (rd_stat) begin
			s_next.stat[PPS_ST_NVM_RD_ERR] = 1'b0;
			s_next.stat[PPS_ST_NVM_WR_ERR] = 1'b0;
		end
		if (recal_start_in || !rst_pin_n_s) begin
			s_next.stat[PPS_ST_UNLOCK] = 1'b0;
		end
		if (recal_start_in) begin
			s_next.stat[PPS_ST_CAL_DONE] = 1'b0;
		end
		if (nvm_op_req_in && nvm_rd_phase_in) begin
			s_next.stat[PPS_ST_NVM_RD_ERR] = 1'b1;
		end
		if (nvm_op_req_in && nvm_wr_phase_in) begin
			s_next.stat[PPS_ST_NVM_WR_ERR] = 1'b1;
		end
		if (reg_rd_in && (reg_addr_in > LAST_REG_ADDR)) begin
			s_next.stat[PPS_ST_RD_ERR] = 1'b1;
		end
		if (reg_wr_in && (reg_addr_in > LAST_REG_ADDR)) begin
			s_next.stat[PPS_ST_WR_ERR] = 1'b1;
		end
		if (nvm_crc_err_in) begin
			s_next.stat[PPS_ST_CRC_ERR] = 1'b1;
		end
		if (cal_done_evt_in) begin
			s_next.stat[PPS_ST_CAL_DONE] = 1'b1;
		end
		if (config_done_evt_in) begin
			s_next.stat[PPS_ST_CFG_DONE] = 1'b1;
		end
		if (s_reg.lock_prev && !lock_s) begin
			s_next.stat[PPS_ST_UNLOCK] = 1'b1;
		end
		// read data
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				PPS_ADDR_PWR: s_next.rdata = s_reg.pwr;
				PPS_ADDR_CAL: s_next.rdata = s_reg.cal;
				PPS_ADDR_STAT: s_next.rdata = s_reg.stat & PPS_STAT_RD_MASK;
				default: s_next.rdata = 16'h0000;
			endcase
		end
	end
	// ==========================================
	// state register
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg.pwr <= PPS_PWR_RST;
			s_reg.cal <= PPS_CAL_RST;
			s_reg.stat <= PPS_STAT_RST;
			s_reg.rdata <= 16'h0000;
			s_reg.pdn <= PPS_PWR_RST[PPS_PDN_W-1:0];
			s_reg.lock_prev <= 1'b0;
			s_reg.por_prev <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end
	// ==========================================
	// outputs
	assign reg_rdata_out = s_reg.rdata;
	assign vco_buffer_regulator_off_out = s_reg.pdn[PPS_PWR_VCOBUF_REG];
	assign vco_regulator_off_out = s_reg.pdn[PPS_PWR_VCO_REG];
	assign vco_buffer_off_out = s_reg.pdn[PPS_PWR_VCOBUF];
	assign charge_pump_regulator_off_out = s_reg.pdn[PPS_PWR_CP_REG];
	assign lock_detector_off_out = s_reg.pdn[PPS_PWR_LOCKDET];
	assign fb_prescaler_off_out = s_reg.pdn[PPS_PWR_FBPS];
	assign prescaler_a_off_out = s_reg.pdn[PPS_PWR_PSA];
	assign fod_clock_path_off_out = s_reg.pdn[PPS_PWR_FODCLK];
	assign phase_detector_off_out = s_reg.pdn[PPS_PWR_PFD];
	assign prescaler_off_out = s_reg.pdn[PPS_PWR_PS];
	assign input_path_regulator_off_out = s_reg.pdn[PPS_PWR_REF];
	// ==========================================
	// assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	property p_pwr_write;
		hit(reg_wr_in, reg_addr_in, PPS_ADDR_PWR) && !por_active_in && !s_reg.por_prev && !cal_done_evt_in
			|=> (s_reg.pdn == $past(reg_wdata_in[10:0])) && (s_reg.pwr == $past(reg_wdata_in));
	endproperty
	a_pwr_write: assert property (p_pwr_write) else $error("power write not applied");
	property p_por_low;
		por_active_in |=> (s_reg.pdn & PPS_PDN_POR_MASK) == 11'h000;
	endproperty
	a_por_low: assert property (p_por_low) else $error("por power-downs not low");
	property p_por_end;
		s_reg.por_prev && !por_active_in && !cal_done_evt_in |=> phase_detector_off_out && prescaler_a_off_out;
	endproperty
	a_por_end: assert property (p_por_end) else $error("por end did not set power-downs");
	property p_pfd_cal;
		cal_done_evt_in |=> !phase_detector_off_out && s_reg.stat[PPS_ST_CAL_DONE];
	endproperty
	a_pfd_cal: assert property (p_pfd_cal) else $error("calibration did not release pfd");
	property p_cal_ro;
		hit(reg_wr_in, reg_addr_in, PPS_ADDR_CAL) && !cal_done_evt_in |=> $stable(s_reg.cal);
	endproperty
	a_cal_ro: assert property (p_cal_ro) else $error("calibration word changed by write");
	property p_cal_cap;
		cal_done_evt_in |=> s_reg.cal == $past(cal_word_in);
	endproperty
	a_cal_cap: assert property (p_cal_cap) else $error("calibration word not captured");
	property p_rd_err_set;
		nvm_op_req_in && nvm_rd_phase_in |=> s_reg.stat[PPS_ST_NVM_RD_ERR];
	endproperty
	a_rd_err_set: assert property (p_rd_err_set) else $error("eeprom read-phase error not set");
	property p_rc_clear;
		rd_stat && !nvm_op_req_in |=> !s_reg.stat[PPS_ST_NVM_RD_ERR] && !s_reg.stat[PPS_ST_NVM_WR_ERR];
	endproperty
	a_rc_clear: assert property (p_rc_clear) else $error("eeprom error flags not cleared by read");
	property p_rd_range;
		reg_rd_in && (reg_addr_in > LAST_REG_ADDR) |=> s_reg.stat[PPS_ST_RD_ERR];
	endproperty
	a_rd_range: assert property (p_rd_range) else $error("read range error not flagged");
	property p_wr_range;
		reg_wr_in && (reg_addr_in > LAST_REG_ADDR) |=> s_reg.stat[PPS_ST_WR_ERR];
	endproperty
	a_wr_range: assert property (p_wr_range) else $error("write range error not flagged");
	property p_busy;
		1'b1 |=> s_reg.stat[PPS_ST_BUSY] == $past(nvm_busy_in);
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag does not follow eeprom");
	property p_unlock;
		s_reg.lock_prev && !lock_s |=> s_reg.stat[PPS_ST_UNLOCK]
			##1 (s_reg.stat[PPS_ST_UNLOCK] || $past(recal_start_in) || !$past(rst_pin_n_s));
	endproperty
	a_unlock: assert property (p_unlock) else $error("loss of lock not sticky");
	property p_stat_read;
		rd_stat |=> reg_rdata_out == ($past(s_reg.stat) & PPS_STAT_RD_MASK);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read data wrong");
	property p_wr_err_set;
		nvm_op_req_in && nvm_wr_phase_in |=> s_reg.stat[PPS_ST_NVM_WR_ERR];
	endproperty
	a_wr_err_set: assert property (p_wr_err_set) else $error("eeprom write-phase error not set");
	property p_crc_set;
		nvm_crc_err_in |=> s_reg.stat[PPS_ST_CRC_ERR];
	endproperty
	a_crc_set: assert property (p_crc_set) else $error("checksum error not flagged");
	property p_crc_sticky;
		s_reg.stat[PPS_ST_CRC_ERR] |=> s_reg.stat[PPS_ST_CRC_ERR];
	endproperty
	a_crc_sticky: assert property (p_crc_sticky) else $error("checksum error flag lost");
	property p_cfg_set;
		config_done_evt_in |=> s_reg.stat[PPS_ST_CFG_DONE];
	endproperty
	a_cfg_set: assert property (p_cfg_set) else $error("configuration done not flagged");
	property p_lock_follow;
		1'b1 |=> s_reg.stat[PPS_ST_LOCK] == $past(lock_s);
	endproperty
	a_lock_follow: assert property (p_lock_follow) else $error("lock flag does not follow pin");
	property p_lock_a_follow;
		1'b1 |=> s_reg.stat[PPS_ST_LOCK_A] == $past(lock_a_s);
	endproperty
	a_lock_a_follow: assert property (p_lock_a_follow) else $error("analog lock flag does not follow pin");
	property p_vpor_follow;
		1'b1 |=> s_reg.stat[PPS_ST_VCO_POR] == $past(vpor_s);
	endproperty
	a_vpor_follow: assert property (p_vpor_follow) else $error("regulator por flag does not follow pin");
	property p_unlock_clear;
		rst_pin_n_s && !recal_start_in && !s_reg.stat[PPS_ST_UNLOCK] && !(s_reg.lock_prev && !lock_s)
			|=> !s_reg.stat[PPS_ST_UNLOCK];
	endproperty
	a_unlock_clear: assert property (p_unlock_clear) else $error("loss of lock set without a lock fall");
	c_unlock: cover property (s_reg.lock_prev && !lock_s ##1 s_reg.stat[PPS_ST_UNLOCK]);
	c_cal_pfd: cover property (cal_done_evt_in ##1 !phase_detector_off_out);
	c_wr_range: cover property (reg_wr_in && (reg_addr_in > LAST_REG_ADDR));
	c_rc: cover property (s_reg.stat[PPS_ST_NVM_RD_ERR] && rd_stat);
	c_por_cal: cover property (por_end ##[1:50] cal_done_evt_in);
endmodule : pps_regs
`default_nettype wire

// ### design/pps_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module pps_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] async_in,
	input wire logic [W-1:0] rst_val_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pps_sync_t;
	pps_sync_t s_reg;
	pps_sync_t s_next;
	// ==========================================
	// first flop feeds only the second; flops hold the level relative to its reset value
	always_comb begin
		s_next.meta = async_in ^ rst_val_in;
		s_next.stable = s_reg.meta;
	end
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign sync_out = s_reg.stable ^ rst_val_in;
endmodule : pps_sync
`default_nettype wire

// ### verif/pps_host.sv
// host model that drives the register access port
`timescale 1ns/10ps
`default_nettype none
module pps_host (
	input wire logic clk_sys_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [15:0] wdata_out,
	input wire logic [15:0] rdata_in
);
	// ==========================================
	// idle lines at time zero
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	// ==========================================
	// one strobe cycle, then address and data scrambled
	task automatic access(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
		@(negedge clk_sys_in);
		addr_out = a;
		wdata_out = d & 16'hFFFE;
		wr_out = w;
		rd_out = ~w;
		@(negedge clk_sys_in);
		q = rdata_in;
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = ~addr_out;
		wdata_out = ~wdata_out;
	endtask : access
endmodule : pps_host
`default_nettype wire

// ### verif/pps_regs_bench.sv
// self-checking bench for the pll power and status register slice
`timescale 1ns/10ps
`default_nettype none
module pps_regs_bench
	import pps_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr;
	logic wr, rd;
	logic [15:0] wdata, rdata;
	logic sync_n = 1'b1, lock = 1'b0, lock_a = 1'b0, vpor = 1'b0, por = 1'b1;
	logic recal = 1'b0, cal_evt = 1'b0, cfg_evt = 1'b0, op = 1'b0;
	logic rdph = 1'b0, wrph = 1'b0, busy = 1'b0, crc = 1'b0;
	logic [15:0] cal_word = 16'h0000;
	wire [10:0] pdn;
	int fail_count = 0;
	int total_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	// ==========================================
	// design and host
	pps_host u_host (.clk_sys_in(clk_sys), .addr_out(addr), .wr_out(wr), .rd_out(rd),
		.wdata_out(wdata), .rdata_in(rdata));
	pps_regs u_dut (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reset_sync_pin_n_in(sync_n),
		.lock_det_in(lock), .lock_det_analog_in(lock_a), .vco_ldo_por_in(vpor), .por_active_in(por),
		.recal_start_in(recal), .cal_done_evt_in(cal_evt), .cal_word_in(cal_word),
		.config_done_evt_in(cfg_evt), .nvm_op_req_in(op), .nvm_rd_phase_in(rdph),
		.nvm_wr_phase_in(wrph), .nvm_busy_in(busy), .nvm_crc_err_in(crc),
		.vco_buffer_regulator_off_out(pdn[10]), .vco_regulator_off_out(pdn[9]),
		.vco_buffer_off_out(pdn[8]), .charge_pump_regulator_off_out(pdn[7]),
		.lock_detector_off_out(pdn[6]), .fb_prescaler_off_out(pdn[5]), .prescaler_a_off_out(pdn[4]),
		.fod_clock_path_off_out(pdn[3]), .phase_detector_off_out(pdn[2]), .prescaler_off_out(pdn[1]),
		.input_path_regulator_off_out(pdn[0]));
	// ==========================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdm(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
		logic [15:0] q;
		u_host.access(a, 1'b0, 16'h0000, q);
		chk(n, e, q & m);
	endtask : rdm
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		u_host.access(a, 1'b1, d, q);
	endtask : wr_reg
	// ==========================================
	// scenarios
	task automatic s_por;
		chk("pdn during por", 16'h0020, {5'h00, pdn});
		rdm(PPS_ADDR_PWR, 16'hFFFF, 16'h0030, "pwr reset");
		rdm(PPS_ADDR_CAL, 16'hFFFF, 16'h0000, "cal reset");
		rdm(PPS_ADDR_STAT, 16'hFFFF, 16'h0000, "stat reset");
		por = 1'b0;
		tick(2);
		chk("pdn after por", 16'h003E, {5'h00, pdn});
	endtask : s_por
	task automatic s_pwr;
		for (int i = 1; i < 11; i++) begin
			wr_reg(PPS_ADDR_PWR, 16'h0001 << i);
			chk("pdn bit", 16'h0001 << i, {5'h00, pdn});
		end
		wr_reg(PPS_ADDR_PWR, 16'h0000);
		rdm(PPS_ADDR_PWR, 16'hFFFF, 16'h0000, "pwr clear");
	endtask : s_pwr
	task automatic s_cal;
		wr_reg(PPS_ADDR_PWR, 16'h0004);
		cal_word = 16'hA5C3;
		cal_evt = 1'b1;
		tick(1);
		cal_evt = 1'b0;
		cal_word = 16'h1111;
		tick(1);
		chk("pfd after cal", 16'h0000, {5'h00, pdn});
		wr_reg(PPS_ADDR_CAL, 16'hFFFF);
		rdm(PPS_ADDR_CAL, 16'hFFFF, 16'hA5C3, "cal word");
		rdm(PPS_ADDR_STAT, 16'h0008, 16'h0008, "cal done");
		recal = 1'b1;
		tick(1);
		recal = 1'b0;
		rdm(PPS_ADDR_STAT, 16'h0008, 16'h0000, "cal done cleared");
	endtask : s_cal
	task automatic s_lock;
		lock = 1'b1;
		lock_a = 1'b1;
		vpor = 1'b1;
		tick(4);
		rdm(PPS_ADDR_STAT, 16'hFC03, 16'h0C01, "lock levels");
		lock = 1'b0;
		tick(4);
		lock = 1'b1;
		tick(4);
		rdm(PPS_ADDR_STAT, 16'h0003, 16'h0003, "unlock sticky");
		wr_reg(PPS_ADDR_STAT, 16'h0000);
		rdm(PPS_ADDR_STAT, 16'h0002, 16'h0002, "unlock kept");
		sync_n = 1'b0;
		tick(4);
		sync_n = 1'b1;
		tick(4);
		rdm(PPS_ADDR_STAT, 16'h0002, 16'h0000, "unlock cleared");
	endtask : s_lock
	task automatic s_nvm;
		busy = 1'b1;
		tick(2);
		rdm(PPS_ADDR_STAT, 16'h0010, 16'h0010, "busy");
		busy = 1'b0;
		tick(2);
		rdm(PPS_ADDR_STAT, 16'h0010, 16'h0000, "busy cleared");
		rdph = 1'b1;
		op = 1'b1;
		tick(1);
		op = 1'b0;
		rdph = 1'b0;
		rdm(PPS_ADDR_STAT, 16'h0300, 16'h0200, "nvm read phase");
		rdm(PPS_ADDR_STAT, 16'h0300, 16'h0000, "read clears");
		wrph = 1'b1;
		op = 1'b1;
		tick(1);
		op = 1'b0;
		wrph = 1'b0;
		rdm(PPS_ADDR_STAT, 16'h0300, 16'h0100, "nvm write phase");
		rdm(PPS_ADDR_STAT, 16'h0300, 16'h0000, "read clears");
		crc = 1'b1;
		cfg_evt = 1'b1;
		tick(1);
		crc = 1'b0;
		cfg_evt = 1'b0;
		rdm(PPS_ADDR_STAT, 16'h0024, 16'h0024, "crc and config");
	endtask : s_nvm
	task automatic s_range;
		rdm(8'h08, 16'hFFFF, 16'h0000, "unmapped read");
		rdm(PPS_ADDR_STAT, 16'h00C0, 16'h0000, "no range flag");
		rdm(8'h40, 16'hFFFF, 16'h0000, "range read");
		rdm(PPS_ADDR_STAT, 16'h00C0, 16'h0080, "read range flag");
		wr_reg(8'h40, 16'hFFFF);
		rdm(PPS_ADDR_STAT, 16'h00C0, 16'h00C0, "write range flag");
	endtask : s_range
	// ==========================================
	// verdict
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	initial begin
		tick(10);
		rst_n = 1'b1;
		tick(2);
		s_por();
		s_pwr();
		s_cal();
		s_lock();
		s_nvm();
		s_range();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		conclude();
	end
endmodule : pps_regs_bench
`default_nettype wire
